// ==== design/shsr_core.sv ====
// Select, address strap and host request handling of the serial host port.
// Assumes mode and controls come from same-clock logic; pins are asynchronous.
`default_nettype none

// Behaviour
// - SPI slave shifts only while active-low select is held low.
// - Select driven low in SPI master mode sets a sticky bus error flag.
// - Select high in SPI slave mode: serial clock edges ignored, MISO held high impedance.
// - I2C slave uses address bit 2 input as part of own address.
// - I2C master ignores address bit 2 input entirely.
// - Slave mode drives host request low when ready for next word.
// - Slave mode releases host request on first clock pulse of a word.
// - Master mode starts a word when the external slave pulls request low.
// - Master waits for a fresh request assertion before the next word.
// - MISO and request pins high impedance during any reset.
// - Address bit 0 used in I2C slave mode, ignored in I2C master mode.
module shsr_core
    import shsr_pkg::*;
#(
    parameter int WORD_BITS = WORD_BITS_DEF,
    parameter logic [6:0] ADDR_BASE = ADDR_BASE_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic port_reset,
    input wire shsr_mode_e mode,
    input wire logic buffer_ready,
    input wire logic error_clear,
    input wire logic slave_select_n,
    input wire logic serial_clock,
    input wire logic i2c_slave_addr_bit2,
    input wire logic i2c_slave_addr_bit0,
    input wire logic host_request_n_in,
    output logic host_request_n_out,
    output logic host_request_n_oe,
    output logic miso_oe,
    output logic shift_enable,
    output logic sck_rise,
    output logic word_start,
    output logic word_done,
    output logic bus_error,
    output logic [6:0] own_address
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    localparam int CNT_W = $clog2(WORD_BITS + 1);

    logic ss_n_s;
    logic sck_s;
    logic ha2_s;
    logic host_request_n_n_s;
    logic ha0_s;
    logic sck_d_r;
    logic host_request_n_d_r;
    logic any_reset;
    logic is_slave;
    logic spi_slave_sel;
    logic sck_edge_ok;
    logic [CNT_W-1:0] bit_cnt_r;
    shsr_req_e req_r;

    // Reset to idle levels (select high, clock low, request released) so no false edge
    shsr_sync #(.WIDTH(5), .RESET_VAL(5'h12)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in({slave_select_n, serial_clock, i2c_slave_addr_bit2,
                   host_request_n_in, i2c_slave_addr_bit0}),
        .sync_out({ss_n_s, sck_s, ha2_s, host_request_n_n_s, ha0_s})
    );

    assign any_reset = soft_reset | port_reset;
    assign is_slave = (mode == SHSR_SPI_SLAVE) || (mode == SHSR_I2C_SLAVE);
    assign spi_slave_sel = (mode == SHSR_SPI_SLAVE) && !ss_n_s;
    // Serial clock rise that may count: in SPI slave mode only while selected
    assign sck_edge_ok = sck_s && !sck_d_r && ((mode != SHSR_SPI_SLAVE) || !ss_n_s);

    ////////////////////////////////////////////////////////////////////////////
    // Edge history of serial clock and host request

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_d_r <= 1'b0;
            host_request_n_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            host_request_n_d_r <= host_request_n_n_s;
        end
    end

    // Serial clock rising edge, qualified by select in SPI slave mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_rise <= 1'b0;
        end else if (any_reset) begin
            sck_rise <= 1'b0;
        end else begin
            sck_rise <= sck_edge_ok;
        end
    end

    // Shift enable and MISO driver enable follow select in SPI slave mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_enable <= 1'b0;
            miso_oe <= 1'b0;
        end else if (any_reset) begin
            shift_enable <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            shift_enable <= (mode == SHSR_SPI_SLAVE) ? !ss_n_s : 1'b1;
            miso_oe <= spi_slave_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus error on select asserted in SPI master mode; set wins over clear

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_error <= 1'b0;
        end else if (any_reset) begin
            bus_error <= 1'b0;
        end else if ((mode == SHSR_SPI_MASTER) && !ss_n_s) begin
            bus_error <= 1'b1;
        end else if (error_clear) begin
            bus_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Own I2C slave address from straps, forced to ADDR_BASE outside I2C slave mode

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            own_address <= ADDR_BASE;
        end else if (mode == SHSR_I2C_SLAVE) begin
            own_address <= ADDR_BASE;
            own_address[ADDR_BIT2_POS] <= ha2_s;
            own_address[ADDR_BIT0_POS] <= ha0_s;
        end else begin
            own_address <= ADDR_BASE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word pacing state machine and bit counter

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_r <= SHSR_IDLE;
            bit_cnt_r <= '0;
            word_start <= 1'b0;
            word_done <= 1'b0;
        end else if (any_reset) begin
            req_r <= SHSR_IDLE;
            bit_cnt_r <= '0;
            word_start <= 1'b0;
            word_done <= 1'b0;
        end else begin
            word_start <= 1'b0;
            word_done <= 1'b0;
            unique case (req_r)
                SHSR_IDLE: begin
                    if (is_slave && buffer_ready) begin
                        req_r <= SHSR_READY;
                    end else if (!is_slave && !host_request_n_n_s && host_request_n_d_r) begin
                        req_r <= SHSR_XFER;
                        word_start <= 1'b1;
                        bit_cnt_r <= '0;
                    end
                end
                SHSR_READY: begin
                    if (!is_slave || !buffer_ready) begin
                        req_r <= SHSR_IDLE;
                    end else if (sck_edge_ok) begin
                        req_r <= SHSR_XFER;
                        word_start <= 1'b1;
                        bit_cnt_r <= CNT_W'(1);
                    end
                end
                SHSR_XFER: begin
                    if (sck_edge_ok) begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                    if (bit_cnt_r == CNT_W'(WORD_BITS)) begin
                        word_done <= 1'b1;
                        req_r <= is_slave ? SHSR_IDLE : SHSR_WAIT_REL;
                    end
                end
                SHSR_WAIT_REL: begin
                    if (is_slave || host_request_n_n_s) begin
                        req_r <= SHSR_IDLE;
                    end
                end
            endcase
        end
    end

    // Host request pin: driven only in slave mode and outside reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            host_request_n_out <= 1'b1;
            host_request_n_oe <= 1'b0;
        end else if (any_reset) begin
            host_request_n_out <= 1'b1;
            host_request_n_oe <= 1'b0;
        end else begin
            host_request_n_oe <= is_slave;
            host_request_n_out <= !(is_slave && req_r == SHSR_READY && buffer_ready
                                   && !sck_edge_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_master_req_fall;
        !is_slave && req_r == SHSR_IDLE && !host_request_n_n_s && host_request_n_d_r;
    endsequence

    a_ss_error_set: assert property (@(posedge clock) disable iff (!rstn)
        (mode == SHSR_SPI_MASTER && !ss_n_s && !any_reset) |=> bus_error)
        else $error("bus error not flagged");

    a_miso_off_desel: assert property (@(posedge clock) disable iff (!rstn)
        ss_n_s |=> !miso_oe)
        else $error("miso driven while deselected");

    a_sck_ignored: assert property (@(posedge clock) disable iff (!rstn)
        (mode == SHSR_SPI_SLAVE && ss_n_s) |=> !sck_rise)
        else $error("serial clock edge seen while deselected");

    a_shift_gate: assert property (@(posedge clock) disable iff (!rstn)
        (mode == SHSR_SPI_SLAVE && $stable(mode) && !any_reset)
        |=> shift_enable == !$past(ss_n_s))
        else $error("shift enable does not follow select");

    a_addr_master: assert property (@(posedge clock) disable iff (!rstn)
        (mode == SHSR_I2C_MASTER) |=> own_address == ADDR_BASE)
        else $error("address strap used in master mode");

    a_addr_slave: assert property (@(posedge clock) disable iff (!rstn)
        (mode == SHSR_I2C_SLAVE) |=> own_address[ADDR_BIT2_POS] == $past(ha2_s)
        && own_address[ADDR_BIT0_POS] == $past(ha0_s))
        else $error("address strap not taken");

    a_master_start: assert property (@(posedge clock) disable iff (!rstn || any_reset)
        s_master_req_fall |=> word_start && req_r == SHSR_XFER)
        else $error("master did not start on request");

    a_wait_fresh: assert property (@(posedge clock) disable iff (!rstn)
        (req_r == SHSR_WAIT_REL && !is_slave && !host_request_n_n_s && !any_reset)
        |=> req_r == SHSR_WAIT_REL && !word_start)
        else $error("master started without fresh request");

    a_req_not_ready: assert property (@(posedge clock) disable iff (!rstn)
        !buffer_ready |=> host_request_n_out)
        else $error("request asserted with no buffer");

    a_reset_hiz: assert property (@(posedge clock) disable iff (!rstn)
        any_reset |=> !host_request_n_oe && !miso_oe)
        else $error("pin driven during reset");

endmodule

`default_nettype wire

// ==== design/shsr_sync.sv ====
// Two-flip-flop synchroniser bank for asynchronous pin inputs.
// Assumes the destination clock is the block clock; reset value is a parameter.
`default_nettype none

module shsr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_r <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ==== shared/shsr_pkg.sv ====
// Constants and types shared by the serial host select and request block.
// Assumes one 100 MHz clock; all pins arrive asynchronous to it.
`default_nettype none

package shsr_pkg;

    // Clock rate and synchroniser depth
    localparam int CLOCK_MHZ = 100;
    localparam int SYNC_STAGES = 2;

    // Default serial data word length in bits
    localparam int WORD_BITS_DEF = 8;

    // Bit positions of the two strap inputs within the own slave address
    localparam int ADDR_BIT0_POS = 0;
    localparam int ADDR_BIT2_POS = 2;

    // Default fixed part of the seven-bit I2C slave address (arbitrary)
    localparam logic [6:0] ADDR_BASE_DEF = 7'h50;

    // Operating mode of the port
    typedef enum logic [1:0] {
        SHSR_SPI_SLAVE,
        SHSR_SPI_MASTER,
        SHSR_I2C_SLAVE,
        SHSR_I2C_MASTER
    } shsr_mode_e;

    // Word pacing state of the host request handshake
    typedef enum logic [1:0] {
        SHSR_IDLE,
        SHSR_READY,
        SHSR_XFER,
        SHSR_WAIT_REL
    } shsr_req_e;

endpackage

`default_nettype wire

// ==== verification/shsr_partner.sv ====
// Model of the far-side SPI or I2C party: select, serial clock and request.
// Assumes the bench calls its tasks; the request line has a pull-up in the bench.
`default_nettype none

module shsr_partner (
    input wire logic clock,
    output logic sel_n,
    output logic sck,
    output logic req_drv_n,
    output logic req_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle pins: select high unless a scenario misbehaves on purpose
    task automatic idle();
        sel_n = 1'b1;
        sck = 1'b0;
        req_drv_n = 1'b1;
        req_oe = 1'b0;
    endtask

    // Serial clock at 125 ns period, standing low between frames
    task automatic pulses(input int n);
        repeat (n) begin
            #62.5;
            sck = 1'b1;
            #62.5;
            sck = 1'b0;
        end
    endtask

    // Far slave pulls request low to ask for a word, or lets it float high
    task automatic request(input logic on);
        @(posedge clock);
        #1;
        req_oe = on;
        req_drv_n = !on;
    endtask

    // Select asserted or released just after a clock edge
    task automatic select(input logic on);
        @(posedge clock);
        #1;
        sel_n = !on;
    endtask
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the select, strap and host request block.
// Assumes the partner model drives the pins; request wire has a pull-up.
`default_nettype none

module tb_top;
    import shsr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock, rstn, soft_reset, port_reset, buffer_ready, error_clear;
    logic addr2, addr0, sel_n, sck, req_drv_n, req_oe, req_wire;
    logic req_out, req_oe_dut, miso_oe, shift_enable, sck_rise, word_start, word_done;
    logic bus_error;
    logic [6:0] own_address;
    shsr_mode_e mode;
    int n_fail = 0, cmp_count = 0, cycles = 0, n_start = 0, n_done = 0, n_rise = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Design, far party and the resolved request wire
    shsr_core i_dut (.clock(clock), .rstn(rstn), .soft_reset(soft_reset),
        .port_reset(port_reset), .mode(mode), .buffer_ready(buffer_ready),
        .error_clear(error_clear), .slave_select_n(sel_n), .serial_clock(sck),
        .i2c_slave_addr_bit2(addr2), .i2c_slave_addr_bit0(addr0),
        .host_request_n_in(req_wire), .host_request_n_out(req_out),
        .host_request_n_oe(req_oe_dut), .miso_oe(miso_oe), .shift_enable(shift_enable),
        .sck_rise(sck_rise), .word_start(word_start), .word_done(word_done),
        .bus_error(bus_error), .own_address(own_address));
    shsr_partner i_partner (.clock(clock), .sel_n(sel_n), .sck(sck),
        .req_drv_n(req_drv_n), .req_oe(req_oe));
    assign req_wire = req_oe_dut ? req_out : (req_oe ? req_drv_n : 1'b1);

    ////////////////////////////////////////////////////////////////////////////
    // Clock, pulse counters and the hang limit
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (word_start === 1'b1) n_start++;
        if (word_done === 1'b1) n_done++;
        if (sck_rise === 1'b1) n_rise++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_resets();
        check("req_oe in reset", req_oe_dut, 1'b0);
        check("miso_oe in reset", miso_oe, 1'b0);
        check("addr in reset", own_address, ADDR_BASE_DEF);
        rstn = 1'b1;
        step(6);
        check("req_oe run", req_oe_dut, 1'b1);
        check("req asserted", req_out, 1'b0);
        soft_reset = 1'b1;
        step(2);
        check("req_oe soft", req_oe_dut, 1'b0);
        soft_reset = 1'b0;
        port_reset = 1'b1;
        step(2);
        check("req_oe port", req_oe_dut, 1'b0);
        port_reset = 1'b0;
        buffer_ready = 1'b0;
        step(6);
    endtask
    task automatic t_slave_word();
        check("req no buffer", req_out, 1'b1);
        n_rise = 0;
        n_start = 0;
        n_done = 0;
        i_partner.pulses(2);
        step(4);
        check("rise deselected", 7'(n_rise), 7'h0);
        check("miso deselected", miso_oe, 1'b0);
        i_partner.select(1'b1);
        buffer_ready = 1'b1;
        step(4);
        check("miso selected", miso_oe, 1'b1);
        check("shift selected", shift_enable, 1'b1);
        check("req ready", req_out, 1'b0);
        i_partner.pulses(1);
        step(4);
        check("req released", req_out, 1'b1);
        check("word started", 7'(n_start), 7'h1);
        i_partner.pulses(7);
        step(4);
        check("rises counted", 7'(n_rise), 7'h8);
        check("word done", 7'(n_done), 7'h1);
        check("req again", req_out, 1'b0);
        buffer_ready = 1'b0;
        i_partner.select(1'b0);
    endtask
    task automatic t_master();
        step(4);
        mode = SHSR_SPI_MASTER;
        step(4);
        check("req is input", req_oe_dut, 1'b0);
        check("no error deselected", bus_error, 1'b0);
        i_partner.select(1'b1);
        step(4);
        check("bus error set", bus_error, 1'b1);
        i_partner.select(1'b0);
        step(3);
        error_clear = 1'b1;
        step(1);
        error_clear = 1'b0;
        step(2);
        check("bus error clear", bus_error, 1'b0);
        n_start = 0;
        n_done = 0;
        i_partner.request(1'b1);
        step(5);
        check("master start", 7'(n_start), 7'h1);
        i_partner.pulses(8);
        step(10);
        check("no restart", 7'(n_start), 7'h1);
        i_partner.request(1'b0);
        step(4);
        i_partner.request(1'b1);
        step(5);
        check("fresh start", 7'(n_start), 7'h2);
        i_partner.pulses(8);
        i_partner.request(1'b0);
        step(6);
        check("master words done", 7'(n_done), 7'h2);
    endtask
    task automatic t_straps();
        mode = SHSR_I2C_SLAVE;
        addr2 = 1'b1;
        addr0 = 1'b1;
        step(5);
        check("addr both", own_address, ADDR_BASE_DEF | 7'h05);
        addr2 = 1'b0;
        step(5);
        check("addr bit0", own_address, ADDR_BASE_DEF | 7'h01);
        mode = SHSR_I2C_MASTER;
        step(5);
        check("addr master idle", own_address, ADDR_BASE_DEF);
        addr2 = 1'b1;
        addr0 = 1'b1;
        step(5);
        check("addr master", own_address, ADDR_BASE_DEF);
    endtask
    task automatic t_init();
        rstn = 1'b0;
        soft_reset = 1'b0;
        port_reset = 1'b0;
        mode = SHSR_SPI_SLAVE;
        buffer_ready = 1'b1;
        error_clear = 1'b0;
        addr2 = 1'b0;
        addr0 = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        i_partner.idle();
        t_init();
        step(20);
        t_resets();
        t_slave_word();
        t_master();
        t_straps();
        end_sim();
    end
endmodule

`default_nettype wire
